// file: pkg/dtc_pkg.sv
// Behaviour
// RULE_01: prescale code picks sysclk/12, /4, /48, extclk/8
// RULE_02: timer1 sysclk bit, ignored when pin counting
// RULE_03: timer0 sysclk bit, ignored when pin counting
// RULE_04: bits 7..4 pick timer2/3 byte clocks
// RULE_05: 13-bit mode uses high byte, low bits 4..0
// RULE_06: 13-bit rollover sets overflow flag, interrupt
// RULE_07: pin select counts falling pin edges
// RULE_08: count only when run and gate satisfied
// RULE_09: run bit never clears the count
// RULE_10: timer1 mirrors timer0, gated by second input
// RULE_11: mode 1 counts all sixteen bits
// RULE_12: mode 2 reloads low byte from high
// RULE_13: software presets low byte before mode 2
// RULE_14: split mode low byte uses timer0 controls
// RULE_15: split high byte runs on timer1 run, flag
// RULE_16: split high byte never counts pin events
// RULE_17: timer1 under split: internal clock, no flag
// RULE_18: timer1 mode 3 always stops
// RULE_19: flag interrupts only when enabled
// RULE_20: pin levels held two clocks, quarter rate
// RULE_21: flag cleared by software or by vectoring
// RULE_22: mode codes 00 13-bit, 01 16-bit, 10 reload
// RULE_23: pins synchronised, falling edge gives count pulse
package dtc_pkg;
    // register indices, byte address is four times the index
    localparam logic [9:0] DTC_IDX_RUN = 10'h088;
    localparam logic [9:0] DTC_IDX_MODE = 10'h089;
    localparam logic [9:0] DTC_IDX_TL0 = 10'h08a;
    localparam logic [9:0] DTC_IDX_TL1 = 10'h08b;
    localparam logic [9:0] DTC_IDX_TH0 = 10'h08c;
    localparam logic [9:0] DTC_IDX_TH1 = 10'h08d;
    localparam logic [9:0] DTC_IDX_CLK = 10'h08e;
    localparam logic [9:0] DTC_IDX_IRQ = 10'h090;
    // reset values
    localparam logic [7:0] DTC_RST_BYTE = 8'h00;
    localparam logic [3:0] DTC_RST_IRQ = 4'h0;
    // clock select register fields
    localparam int DTC_CK_T1SYS = 3;
    localparam int DTC_CK_T0SYS = 2;
    localparam int DTC_CK_DIV = 0;
    // run and flag register fields
    localparam int DTC_RN_TF1 = 7;
    localparam int DTC_RN_TR1 = 6;
    localparam int DTC_RN_TF0 = 5;
    localparam int DTC_RN_TR0 = 4;
    // mode register fields
    localparam int DTC_MD_TIMER1_GATE_EN = 7;
    localparam int DTC_MD_CT1 = 6;
    localparam int DTC_MD_M1 = 4;
    localparam int DTC_MD_TIMER0_GATE_EN = 3;
    localparam int DTC_MD_CT0 = 2;
    localparam int DTC_MD_M0 = 0;
    // interrupt control register fields
    localparam int DTC_IQ_ET0 = 0;
    localparam int DTC_IQ_ET1 = 1;
    localparam int DTC_IQ_POLA = 2;
    localparam int DTC_IQ_POLB = 3;
    // mode codes
    localparam logic [1:0] DTC_MODE_13 = 2'b00;
    localparam logic [1:0] DTC_MODE_16 = 2'b01;
    localparam logic [1:0] DTC_MODE_RELOAD = 2'b10;
    localparam logic [1:0] DTC_MODE_SPLIT = 2'b11;
    // prescale codes and divide counts
    localparam logic [1:0] DTC_SCA_12 = 2'b00;
    localparam logic [1:0] DTC_SCA_4 = 2'b01;
    localparam logic [1:0] DTC_SCA_48 = 2'b10;
    localparam logic [1:0] DTC_SCA_EXT = 2'b11;
    localparam logic [5:0] DTC_DIV_12 = 6'h0c;
    localparam logic [5:0] DTC_DIV_4 = 6'h04;
    localparam logic [5:0] DTC_DIV_48 = 6'h30;
    localparam logic [2:0] DTC_EXT_LAST = 3'h7;
    // pin bit positions in the pin vector
    localparam int DTC_PIN_T0 = 0;
    localparam int DTC_PIN_T1 = 1;
    localparam int DTC_PIN_IRQA = 2;
    localparam int DTC_PIN_IRQB = 3;
    localparam int DTC_PIN_EXT = 4;
    localparam int DTC_NPIN = 5;
    // external pins, sampled asynchronously
    typedef struct packed {
        logic ext_clk;
        logic ext_irq_b;
        logic ext_irq_a;
        logic t1_pin;
        logic t0_pin;
    } dtc_pins_t;
    // one counting step of a timer
    typedef struct packed {
        logic [7:0] tl;
        logic [7:0] th;
        logic ovf;
    } dtc_step_t;
endpackage

// file: core/dtc_timers.sv
`timescale 1ns/1ps
module dtc_timers import dtc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dtc_pins_t pins,
    input wire logic timer0_irq_ack,
    input wire logic timer1_irq_ack,
    output logic timer0_irq,
    output logic timer1_irq,
    output logic timer1_ovf_pulse,
    output logic timer3_hi_clk_sel,
    output logic timer3_lo_clk_sel,
    output logic timer2_hi_clk_sel,
    output logic timer2_lo_clk_sel
);
    // divide count for a prescale code
    function automatic logic [5:0] dtc_div(input logic [1:0] sca);
        logic [5:0] d;
        d = DTC_DIV_12;
        unique case (sca)
            DTC_SCA_12: d = DTC_DIV_12;
            DTC_SCA_4: d = DTC_DIV_4;
            DTC_SCA_48: d = DTC_DIV_48;
            DTC_SCA_EXT: d = DTC_DIV_12;
        endcase
        return d;
    endfunction

    // one increment of a timer in the given mode
    function automatic dtc_step_t dtc_step(input logic [1:0] mode, input logic [7:0] tl,
                                           input logic [7:0] th);
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0] c8;
        dtc_step_t r;
        c13 = {1'b0, th, tl[4:0]} + 14'h0001;
        c16 = {1'b0, th, tl} + 17'h00001;
        c8 = {1'b0, tl} + 9'h001;
        r.tl = tl;
        r.th = th;
        r.ovf = 1'b0;
        unique case (mode) // [RULE_22]
            DTC_MODE_13: begin // upper low bits left as they are [RULE_05]
                r.th = c13[12:5];
                r.tl = {tl[7:5], c13[4:0]};
                r.ovf = c13[13]; // [RULE_06]
            end
            DTC_MODE_16: begin // full sixteen-bit count [RULE_11]
                r.th = c16[15:8];
                r.tl = c16[7:0];
                r.ovf = c16[16];
            end
            DTC_MODE_RELOAD: begin // reload low from high, high kept [RULE_12]
                r.tl = c8[8] ? th : c8[7:0];
                r.ovf = c8[8];
            end
            DTC_MODE_SPLIT: begin // low byte as free 8-bit counter [RULE_14]
                r.tl = c8[7:0];
                r.ovf = c8[8];
            end
        endcase
        return r;
    endfunction

    // apb decode
    logic [9:0] idx; // word index
    logic hit; // mapped word
    logic wr; // write takes effect
    logic [7:0] wb; // write byte
    assign idx = paddr[11:2];
    assign wb = pwdata[7:0];
    assign wr = psel && penable && pwrite && hit;
    always_comb begin
        hit = 1'b0;
        if (paddr[1:0] == 2'b00) begin
            unique case (idx)
                DTC_IDX_RUN, DTC_IDX_MODE, DTC_IDX_TL0, DTC_IDX_TL1,
                DTC_IDX_TH0, DTC_IDX_TH1, DTC_IDX_CLK, DTC_IDX_IRQ: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end
    end
    assign pready = 1'b1; // no wait states
    assign pslverr = psel && penable && !hit; // unmapped word

    // software-visible state
    logic [7:0] clk_r; // clock select register
    logic [7:0] mode_r; // mode register
    logic [3:0] irq_r; // enables and polarities
    logic tr0_r; // timer0 run
    logic tr1_r; // timer1 run
    logic tf0_r; // timer0 overflow flag
    logic tf1_r; // timer1 overflow flag
    logic [7:0] tl0_r;
    logic [7:0] th0_r;
    logic [7:0] tl1_r;
    logic [7:0] th1_r;

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_r <= DTC_RST_BYTE;
            mode_r <= DTC_RST_BYTE;
            irq_r <= DTC_RST_IRQ;
            tr0_r <= 1'b0;
            tr1_r <= 1'b0;
        end else begin
            if (wr && idx == DTC_IDX_CLK) begin
                clk_r <= wb;
            end
            if (wr && idx == DTC_IDX_MODE) begin
                mode_r <= wb;
            end
            if (wr && idx == DTC_IDX_IRQ) begin
                irq_r <= wb[3:0];
            end
            if (wr && idx == DTC_IDX_RUN) begin // run bits leave counts alone [RULE_09]
                tr0_r <= wb[DTC_RN_TR0];
                tr1_r <= wb[DTC_RN_TR1];
            end
        end
    end

    // timer2/3 byte clock selects go straight out [RULE_04]
    assign timer3_hi_clk_sel = clk_r[7];
    assign timer3_lo_clk_sel = clk_r[6];
    assign timer2_hi_clk_sel = clk_r[5];
    assign timer2_lo_clk_sel = clk_r[4];

    // three-flop pin synchronisers, level accepted once stages two and three agree
    logic [DTC_NPIN-1:0] s1_r; // first stage, read only by s2_r
    logic [DTC_NPIN-1:0] s2_r;
    logic [DTC_NPIN-1:0] s3_r;
    logic [DTC_NPIN-1:0] lvl_r; // accepted level
    logic [DTC_NPIN-1:0] fall_r; // one-cycle falling edge pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            lvl_r <= '0;
            fall_r <= '0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < DTC_NPIN; i++) begin // levels held two clocks pass [RULE_20]
                if (s2_r[i] == s3_r[i]) begin
                    lvl_r[i] <= s3_r[i];
                end
                fall_r[i] <= lvl_r[i] && (s2_r[i] == s3_r[i]) && !s3_r[i]; // [RULE_23]
            end
        end
    end

    // prescaler: sysclk divider, or external clock edges divided by eight
    logic [1:0] sca;
    logic [5:0] div_cnt_r;
    logic [2:0] ext_cnt_r;
    logic presc_tick; // prescaled clock enable
    assign sca = clk_r[DTC_CK_DIV +: 2];
    always_comb begin
        if (sca == DTC_SCA_EXT) begin // [RULE_01]
            presc_tick = fall_r[DTC_PIN_EXT] && ext_cnt_r == DTC_EXT_LAST;
        end else begin
            presc_tick = div_cnt_r == dtc_div(sca) - 6'h01; // [RULE_01]
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= '0;
            ext_cnt_r <= '0;
        end else begin
            if (div_cnt_r >= dtc_div(sca) - 6'h01) begin
                div_cnt_r <= '0;
            end else begin
                div_cnt_r <= div_cnt_r + 6'h01;
            end
            if (fall_r[DTC_PIN_EXT]) begin
                ext_cnt_r <= ext_cnt_r + 3'h1;
            end
        end
    end

    // count enables
    logic [1:0] m0;
    logic [1:0] m1;
    logic split; // timer0 in split mode
    logic irqa_act; // gate input a active
    logic irqb_act; // gate input b active
    logic ext_irq_a_tick; // timer0 internal clock
    logic ext_irq_b_tick; // timer1 internal clock
    logic t0_go; // timer0 (or low byte) counts
    logic t0h_go; // split high byte counts
    logic t1_go; // timer1 counts
    assign m0 = mode_r[DTC_MD_M0 +: 2];
    assign m1 = mode_r[DTC_MD_M1 +: 2];
    assign split = m0 == DTC_MODE_SPLIT;
    assign irqa_act = lvl_r[DTC_PIN_IRQA] == irq_r[DTC_IQ_POLA];
    assign irqb_act = lvl_r[DTC_PIN_IRQB] == irq_r[DTC_IQ_POLB]; // [RULE_10]
    assign ext_irq_a_tick = clk_r[DTC_CK_T0SYS] ? 1'b1 : presc_tick; // [RULE_03]
    assign ext_irq_b_tick = clk_r[DTC_CK_T1SYS] ? 1'b1 : presc_tick; // [RULE_02]
    always_comb begin
        // pin edges replace internal clock when pin counting [RULE_07]
        t0_go = (mode_r[DTC_MD_CT0] ? fall_r[DTC_PIN_T0] : ext_irq_a_tick)
            && tr0_r && (!mode_r[DTC_MD_TIMER0_GATE_EN] || irqa_act); // [RULE_08] [RULE_14]
        // split high byte: internal clock only, run from timer1 [RULE_15] [RULE_16]
        t0h_go = split && tr1_r && ext_irq_a_tick;
        if (m1 == DTC_MODE_SPLIT) begin
            t1_go = 1'b0; // [RULE_18]
        end else if (split) begin
            t1_go = ext_irq_b_tick; // internal clock, run by mode only [RULE_17]
        end else begin
            t1_go = (mode_r[DTC_MD_CT1] ? fall_r[DTC_PIN_T1] : ext_irq_b_tick)
                && tr1_r && (!mode_r[DTC_MD_TIMER1_GATE_EN] || irqb_act); // [RULE_10]
        end
    end

    // step results
    dtc_step_t s0;
    dtc_step_t s1;
    logic ovf0; // timer0 overflow event
    logic ovf0h; // split high byte overflow event
    logic ovf1; // timer1 overflow event
    assign s0 = dtc_step(m0, tl0_r, th0_r);
    assign s1 = dtc_step(m1, tl1_r, th1_r);
    assign ovf0 = t0_go && s0.ovf;
    assign ovf0h = t0h_go && th0_r == 8'hff;
    assign ovf1 = t1_go && s1.ovf;

    // timer0 bytes, software write wins over a count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tl0_r <= DTC_RST_BYTE;
            th0_r <= DTC_RST_BYTE;
        end else begin
            if (wr && idx == DTC_IDX_TL0) begin // preset before run [RULE_13]
                tl0_r <= wb;
            end else if (t0_go) begin
                tl0_r <= s0.tl;
            end
            if (wr && idx == DTC_IDX_TH0) begin
                th0_r <= wb;
            end else if (t0h_go) begin
                th0_r <= th0_r + 8'h01; // [RULE_15]
            end else if (t0_go && !split) begin
                th0_r <= s0.th;
            end
        end
    end

    // timer1 bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tl1_r <= DTC_RST_BYTE;
            th1_r <= DTC_RST_BYTE;
        end else begin
            if (wr && idx == DTC_IDX_TL1) begin
                tl1_r <= wb;
            end else if (t1_go) begin
                tl1_r <= s1.tl;
            end
            if (wr && idx == DTC_IDX_TH1) begin
                th1_r <= wb;
            end else if (t1_go) begin
                th1_r <= s1.th;
            end
        end
    end

    // overflow flags: hardware set wins over software or vector clear
    logic wr_run;
    logic tf0_set;
    logic tf1_set;
    assign wr_run = wr && idx == DTC_IDX_RUN;
    assign tf0_set = ovf0 || (wr_run && wb[DTC_RN_TF0]);
    assign tf1_set = ovf0h || (ovf1 && !split) || (wr_run && wb[DTC_RN_TF1]); // [RULE_17]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tf0_r <= 1'b0;
            tf1_r <= 1'b0;
        end else begin
            if (tf0_set) begin
                tf0_r <= 1'b1; // [RULE_06]
            end else if (wr_run || timer0_irq_ack) begin
                tf0_r <= 1'b0; // [RULE_21]
            end
            if (tf1_set) begin
                tf1_r <= 1'b1;
            end else if (wr_run || timer1_irq_ack) begin
                tf1_r <= 1'b0; // [RULE_21]
            end
        end
    end

    // timer1 overflow pulse for baud and conversion users
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer1_ovf_pulse <= 1'b0;
        end else begin
            timer1_ovf_pulse <= ovf1; // [RULE_17]
        end
    end

    // interrupt requests
    assign timer0_irq = tf0_r && irq_r[DTC_IQ_ET0]; // [RULE_19]
    assign timer1_irq = tf1_r && irq_r[DTC_IQ_ET1]; // [RULE_19]

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable) begin
            prdata <= '0;
            if (paddr[1:0] == 2'b00) begin
                unique case (idx)
                    DTC_IDX_RUN: prdata[7:0] <= {tf1_r, tr1_r, tf0_r, tr0_r, 4'h0};
                    DTC_IDX_MODE: prdata[7:0] <= mode_r;
                    DTC_IDX_TL0: prdata[7:0] <= tl0_r;
                    DTC_IDX_TL1: prdata[7:0] <= tl1_r;
                    DTC_IDX_TH0: prdata[7:0] <= th0_r;
                    DTC_IDX_TH1: prdata[7:0] <= th1_r;
                    DTC_IDX_CLK: prdata[7:0] <= clk_r;
                    DTC_IDX_IRQ: prdata[3:0] <= irq_r;
                    default: prdata <= '0;
                endcase
            end
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_any;
    assign wr_any = psel && penable && pwrite;

    sequence s_div4_quiet;
        presc_tick && sca == DTC_SCA_4 && !wr_any ##1 (!wr_any)[*3];
    endsequence
    a_div4_period: assert property (s_div4_quiet |=> presc_tick) // [RULE_01]
        else $error("prescaler divide by four period wrong");

    a_t0_sysclk_inc: assert property ((tr0_r && !mode_r[DTC_MD_TIMER0_GATE_EN] && !mode_r[DTC_MD_CT0]
        && clk_r[DTC_CK_T0SYS] && m0 == DTC_MODE_16 && !wr_any)
        |=> {th0_r, tl0_r} == $past({th0_r, tl0_r}) + 16'h0001) // [RULE_03]
        else $error("timer0 on system clock did not step by one");

    a_pin_no_edge: assert property ((mode_r[DTC_MD_CT0] && !fall_r[DTC_PIN_T0] && !split
        && !wr_any) |=> $stable({th0_r, tl0_r})) // [RULE_07]
        else $error("timer0 moved without a pin edge");

    a_gate_holds: assert property ((mode_r[DTC_MD_TIMER0_GATE_EN] && !irqa_act && !split && !wr_any)
        |=> $stable({th0_r, tl0_r})) // [RULE_08]
        else $error("gated timer0 moved while input inactive");

    a_mode0_roll: assert property ((m0 == DTC_MODE_13 && t0_go && th0_r == 8'hff
        && tl0_r[4:0] == 5'h1f && !wr_any)
        |=> tf0_r && th0_r == 8'h00 && tl0_r[4:0] == 5'h00) // [RULE_06]
        else $error("13-bit rollover wrong");

    a_reload_copy: assert property ((m0 == DTC_MODE_RELOAD && t0_go && tl0_r == 8'hff
        && !wr_any) |=> tf0_r && tl0_r == $past(th0_r) && $stable(th0_r)) // [RULE_12]
        else $error("auto-reload did not copy high byte");

    sequence s_split_hi_wrap;
        split && t0h_go && th0_r == 8'hff && !wr_any;
    endsequence
    a_split_hi_flag: assert property (s_split_hi_wrap |=> tf1_r && th0_r == 8'h00) // [RULE_15]
        else $error("split high byte overflow did not set timer1 flag");

    a_t1_no_flag: assert property ((split && ovf1 && !ovf0h && !tf1_r && !wr_any)
        |=> !tf1_r && timer1_ovf_pulse) // [RULE_17]
        else $error("timer1 flag set while timer0 split");

    a_t1_mode3_stop: assert property ((m1 == DTC_MODE_SPLIT && !wr_any)
        |=> $stable({th1_r, tl1_r})) // [RULE_18]
        else $error("timer1 counted in mode 3");

    a_irq_enable: assert property ((ovf0 && irq_r[DTC_IQ_ET0] && !wr_any) |=> timer0_irq) // [RULE_19]
        else $error("enabled overflow gave no interrupt");

    a_ack_clears: assert property ((timer0_irq_ack && !ovf0 && !wr_any) |=> !tf0_r) // [RULE_21]
        else $error("vector acknowledge did not clear flag");

    a_fall_single: assert property (fall_r[DTC_PIN_T0] |=> !fall_r[DTC_PIN_T0]) // [RULE_23]
        else $error("pin edge pulse longer than one cycle");
endmodule // dtc_timers

// file: testbench/dtc_timers_tb_top.sv
`timescale 1ns/1ps
module dtc_timers_tb_top import dtc_pkg::*;;
    logic pclk = 1'b0; // system clock
    logic presetn = 1'b0; // active low reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb control
    logic [11:0] paddr = 12'h000; // byte address
    logic [31:0] pwdata = 32'h0, prdata; // apb data
    logic pready, pslverr; // apb answer
    dtc_pins_t pins = 5'h07; // irq a high, irq b low, pins high, extclk low
    logic ack0 = 1'b0, ack1 = 1'b0; // vector acknowledges
    logic irq0, irq1; // interrupt requests
    logic t1ovp; // timer1 overflow pulse
    logic [3:0] csel; // timer2/3 byte clock selects
    logic [31:0] rdat; // last read data
    logic rerr; // last read error
    int fails = 0, n_checks = 0, cyc = 0, n_ovp = 0; // counters

    dtc_timers dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .timer0_irq_ack(ack0), .timer1_irq_ack(ack1),
        .timer0_irq(irq0), .timer1_irq(irq1), .timer1_ovf_pulse(t1ovp),
        .timer3_hi_clk_sel(csel[3]), .timer3_lo_clk_sel(csel[2]),
        .timer2_hi_clk_sel(csel[1]), .timer2_lo_clk_sel(csel[0]));

    // 100 mhz clock
    always #5 pclk = ~pclk;

    // hang guard and overflow pulse count
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (t1ovp === 1'b1) n_ovp <= n_ovp + 1;
        if (cyc == 30000) begin
            fails = fails + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // inclusive range compare for counts with phase slack
    task automatic rng(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                       input logic [31:0] g);
        n_checks++;
        if ($isunknown(g) || g < lo || g > hi) begin
            fails++;
            $display("mismatch %s expected %h..%h seen %h", nm, lo, hi, g);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rd(input logic [9:0] idx);
        apb(1'b0, idx, 8'h00);
    endtask

    // preload both bytes of timer0 and set mode and clock
    task automatic setup0(input logic [7:0] md, input logic [7:0] ck, input logic [7:0] th,
                          input logic [7:0] tl);
        wr(DTC_IDX_MODE, md);
        wr(DTC_IDX_CLK, ck);
        wr(DTC_IDX_TH0, th);
        wr(DTC_IDX_TL0, tl);
    endtask

    // reset values, unmapped access, timer2/3 select outputs
    task automatic t_regs();
        logic [9:0] ix[8] = '{DTC_IDX_RUN, DTC_IDX_MODE, DTC_IDX_TL0, DTC_IDX_TL1,
                              DTC_IDX_TH0, DTC_IDX_TH1, DTC_IDX_CLK, DTC_IDX_IRQ};
        foreach (ix[i]) begin
            rd(ix[i]);
            chk("reset value", 32'h0, rdat);
        end
        rd(10'h091);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        chk("unmapped data", 32'h0, rdat);
        wr(DTC_IDX_CLK, 8'ha0);
        @(posedge pclk);
        chk("t23 clock selects", 32'ha, {28'h0, csel});
        $display("test regs done");
    endtask

    // 16-bit rollover, enabled interrupt, vector clears flag
    task automatic t_mode16();
        wr(DTC_IDX_IRQ, 8'h01);
        setup0(8'h01, 8'h04, 8'hff, 8'hfe);
        wr(DTC_IDX_RUN, 8'h10);
        repeat (4) @(posedge pclk);
        rd(DTC_IDX_RUN);
        chk("tf0 set", 32'h20, rdat & 32'h20);
        chk("irq0 high", 32'h1, {31'h0, irq0});
        @(posedge pclk) ack0 <= 1'b1;
        @(posedge pclk) ack0 <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("irq0 after ack", 32'h0, {31'h0, irq0});
        wr(DTC_IDX_RUN, 8'h00);
        rd(DTC_IDX_TH0);
        chk("th0 wrapped", 32'h0, rdat);
        rd(DTC_IDX_TL0);
        rng("tl0 after wrap", 32'h1, 32'h20, rdat);
        $display("test mode16 done");
    endtask

    // 13-bit rollover starting at 1ffe, interrupt masked
    task automatic t_mode13();
        wr(DTC_IDX_IRQ, 8'h00);
        setup0(8'h00, 8'h04, 8'hff, 8'h1e);
        wr(DTC_IDX_RUN, 8'h10);
        repeat (10) @(posedge pclk);
        rd(DTC_IDX_RUN);
        chk("tf0 13-bit", 32'h20, rdat & 32'h20);
        chk("irq0 masked", 32'h0, {31'h0, irq0});
        wr(DTC_IDX_RUN, 8'h00);
        rd(DTC_IDX_RUN);
        chk("tf0 sw clear", 32'h0, rdat);
        rd(DTC_IDX_TH0);
        chk("th0 13-bit", 32'h0, rdat);
        rd(DTC_IDX_TL0);
        rng("tl0 low five", 32'h1, 32'h1f, rdat & 32'h1f);
        $display("test mode13 done");
    endtask

    // auto-reload of low byte from high byte
    task automatic t_reload();
        setup0(8'h02, 8'h04, 8'hc0, 8'hfc);
        wr(DTC_IDX_RUN, 8'h10);
        repeat (10) @(posedge pclk);
        rd(DTC_IDX_RUN);
        chk("tf0 reload", 32'h20, rdat & 32'h20);
        wr(DTC_IDX_RUN, 8'h00);
        rd(DTC_IDX_TH0);
        chk("th0 kept", 32'hc0, rdat);
        rd(DTC_IDX_TL0);
        rng("tl0 reloaded", 32'hc1, 32'hd8, rdat);
        $display("test reload done");
    endtask

    // gating by both irq lines with opposite polarity
    task automatic t_gate();
        wr(DTC_IDX_IRQ, 8'h08);
        pins.ext_irq_a <= 1'b1;
        pins.ext_irq_b <= 1'b0;
        setup0(8'h99, 8'h0c, 8'h00, 8'h00);
        wr(DTC_IDX_TH1, 8'h00);
        wr(DTC_IDX_TL1, 8'h00);
        wr(DTC_IDX_RUN, 8'h50);
        repeat (20) @(posedge pclk);
        rd(DTC_IDX_TL0);
        chk("tl0 gated off", 32'h0, rdat);
        rd(DTC_IDX_TL1);
        chk("tl1 gated off", 32'h0, rdat);
        pins.ext_irq_a <= 1'b0;
        pins.ext_irq_b <= 1'b1;
        repeat (20) @(posedge pclk);
        rd(DTC_IDX_TL0);
        rng("tl0 gated on", 32'h8, 32'h30, rdat);
        rd(DTC_IDX_TL1);
        rng("tl1 gated on", 32'h8, 32'h30, rdat);
        wr(DTC_IDX_RUN, 8'h00);
        $display("test gate done");
    endtask

    // pin counting, sysclk select ignored
    task automatic t_pin();
        setup0(8'h05, 8'h04, 8'h00, 8'h00);
        wr(DTC_IDX_RUN, 8'h10);
        repeat (3) begin
            pins.t0_pin <= 1'b0;
            repeat (4) @(posedge pclk);
            pins.t0_pin <= 1'b1;
            repeat (4) @(posedge pclk);
        end
        repeat (8) @(posedge pclk);
        rd(DTC_IDX_TL0);
        chk("tl0 pin falls", 32'h3, rdat);
        wr(DTC_IDX_RUN, 8'h00);
        $display("test pin done");
    endtask

    // prescaler codes: three sysclk divisors then extclk/8
    task automatic t_presc();
        logic [7:0] dv[3] = '{8'h0c, 8'h04, 8'h30};
        for (int c = 0; c < 3; c++) begin
            setup0(8'h01, c[7:0], 8'h00, 8'h00);
            wr(DTC_IDX_RUN, 8'h10);
            repeat (477) @(posedge pclk);
            wr(DTC_IDX_RUN, 8'h00);
            rd(DTC_IDX_TL0);
            rng("prescaled count", 480 / dv[c] - 1, 480 / dv[c] + 1, rdat);
        end
        setup0(8'h01, 8'h03, 8'h00, 8'h00);
        wr(DTC_IDX_RUN, 8'h10);
        repeat (16) begin
            pins.ext_clk <= 1'b1;
            repeat (4) @(posedge pclk);
            pins.ext_clk <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        repeat (8) @(posedge pclk);
        rd(DTC_IDX_TL0);
        chk("extclk count", 32'h2, rdat);
        wr(DTC_IDX_RUN, 8'h00);
        $display("test prescale done");
    endtask

    // split mode: high byte on timer1 run, timer1 by mode only
    task automatic t_split();
        logic [31:0] v;
        int b;
        b = n_ovp;
        wr(DTC_IDX_IRQ, 8'h02);
        setup0(8'h27, 8'h0c, 8'hfc, 8'h00);
        wr(DTC_IDX_TL1, 8'hfe); // timer1 reload wraps before th0 runs
        wr(DTC_IDX_RUN, 8'h40);
        repeat (10) @(posedge pclk);
        rd(DTC_IDX_RUN);
        chk("tf1 from th0", 32'h80, rdat & 32'ha0);
        chk("irq1 high", 32'h1, {31'h0, irq1});
        rd(DTC_IDX_TL0);
        chk("tl0 stopped", 32'h0, rdat);
        rd(DTC_IDX_TL1);
        rng("tl1 runs", 32'h1, 32'h40, rdat);
        wr(DTC_IDX_MODE, 8'h33);
        rd(DTC_IDX_TL1);
        v = rdat;
        repeat (10) @(posedge pclk);
        rd(DTC_IDX_TL1);
        chk("tl1 mode3 held", v, rdat);
        chk("t1 ovf pulses", 32'h1, n_ovp - b);
        wr(DTC_IDX_RUN, 8'h00);
        $display("test split done");
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_mode16();
        t_mode13();
        t_reload();
        t_gate();
        t_pin();
        t_presc();
        t_split();
        print_verdict();
    end
endmodule // dtc_timers_tb_top
